// File: shared/sbtc_regs.svh
`ifndef SBTC_REGS_SVH
`define SBTC_REGS_SVH

// register indexes; byte address is four times the index
`define SBTC_IDX_CORE_INT_CTRL   8'h0B
`define SBTC_IDX_PERIPH_FLAGS    8'h0C
`define SBTC_IDX_COUNT_LOW       8'h0E
`define SBTC_IDX_COUNT_HIGH      8'h0F
`define SBTC_IDX_COUNTER_CTRL    8'h10
`define SBTC_IDX_PERIPH_ENABLES  8'h8C

// counter_control fields
`define SBTC_CTRL_RUN_BIT        0
`define SBTC_CTRL_SRC_BIT        1
`define SBTC_CTRL_BYPASS_BIT     2
`define SBTC_CTRL_OSCEN_BIT      3
`define SBTC_CTRL_PS_LSB         4
`define SBTC_CTRL_PS_MSB         5
`define SBTC_CTRL_MASK           8'h3F

// flag and enable bank fields
`define SBTC_OVF_BIT             0

// reset values
`define SBTC_CTRL_RESET          8'h00
`define SBTC_FLAGS_RESET         8'h00
`define SBTC_ENABLES_RESET       8'h00
`define SBTC_INTCTRL_RESET       8'h00

// compare mode code for the special event trigger
`define SBTC_CMP_SPECIAL         4'hB

// instruction cycle is four core clocks
`define SBTC_INSTR_DIV           2'h3

`endif

// File: shared/sbtc_pkg.sv
`default_nettype none

package sbtc_pkg;

  typedef enum {
    SBTC_MODE_TIMER,
    SBTC_MODE_SYNC,
    SBTC_MODE_ASYNC
  } sbtc_mode_t;

  typedef enum {
    SBTC_BUS_IDLE,
    SBTC_BUS_ANSWER
  } sbtc_bus_state_t;

endpackage

`default_nettype wire

// File: logic/sbtc_timer.sv
`timescale 1ns/1ps
`include "sbtc_regs.svh"
`default_nettype none

module sbtc_timer (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic [9:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        OSC_INPUT_PIN,
  input  wire logic        EXT_COUNT_CLOCK_PIN,
  input  wire logic        SLEEP,
  input  wire logic [3:0]  CMP1_MODE_SELECT,
  input  wire logic        CMP1_MATCH,
  input  wire logic [3:0]  CMP2_MODE_SELECT,
  input  wire logic        CMP2_MATCH,
  output logic             OSC_AMP_ENABLE,
  output logic             TIMEBASE_VALID,
  output logic [15:0]      TIMEBASE_COUNT,
  output logic             OVERFLOW_IRQ,
  output logic             WAKE_REQUEST
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // prescaler output event: all selected low bits at one before the step
  function automatic logic ps_hit(input logic [2:0] cnt, input logic [1:0] sel);
    logic [2:0] mask;
    mask = 3'h0;
    case (sel)
      2'h0:    mask = 3'h0;
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      default: mask = 3'h7;
    endcase
    return (cnt & mask) == mask;
  endfunction

  function automatic logic [7:0] byte_merge(input logic [7:0] old, input logic [31:0] wd,
                                            input logic be0);
    return be0 ? wd[7:0] : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers and state

  logic [7:0]  ctrl_r;
  logic [7:0]  flags_r;
  logic [7:0]  enables_r;
  logic [7:0]  intctrl_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [2:0]  presc_r;
  logic [1:0]  instr_div_r;
  logic        osc_s1_r, osc_s2_r, osc_d_r;
  logic        ext_s1_r, ext_s2_r, ext_d_r;
  logic        presc_tgl_r;
  logic        tgl_s1_r, tgl_s2_r, tgl_d_r;
  logic [31:0] rdata_r;
  sbtc_pkg::sbtc_bus_state_t bus_state_r;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  wire        run         = ctrl_r[`SBTC_CTRL_RUN_BIT];
  wire        src_ext     = ctrl_r[`SBTC_CTRL_SRC_BIT];
  wire        bypass      = ctrl_r[`SBTC_CTRL_BYPASS_BIT];
  wire        osc_en      = ctrl_r[`SBTC_CTRL_OSCEN_BIT];
  wire [1:0]  ps_sel      = ctrl_r[`SBTC_CTRL_PS_MSB:`SBTC_CTRL_PS_LSB];

  sbtc_pkg::sbtc_mode_t mode;
  assign mode = !src_ext ? sbtc_pkg::SBTC_MODE_TIMER :
                bypass   ? sbtc_pkg::SBTC_MODE_ASYNC : sbtc_pkg::SBTC_MODE_SYNC;

  wire        req         = AVS_READ | AVS_WRITE;
  wire        take        = req && bus_state_r == sbtc_pkg::SBTC_BUS_ANSWER;
  wire [7:0]  idx         = AVS_ADDRESS[9:2];
  wire        aligned     = AVS_ADDRESS[1:0] == 2'h0;
  wire        wr          = take && AVS_WRITE && aligned && AVS_BYTEENABLE[0];
  wire        wr_intctrl  = wr && idx == `SBTC_IDX_CORE_INT_CTRL;
  wire        wr_flags    = wr && idx == `SBTC_IDX_PERIPH_FLAGS;
  wire        wr_low      = wr && idx == `SBTC_IDX_COUNT_LOW;
  wire        wr_high     = wr && idx == `SBTC_IDX_COUNT_HIGH;
  wire        wr_ctrl     = wr && idx == `SBTC_IDX_COUNTER_CTRL;
  wire        wr_enables  = wr && idx == `SBTC_IDX_PERIPH_ENABLES;
  wire        wr_count    = wr_low | wr_high;

  // input edge: crystal pin when enabled, else external pin; synchronised first
  wire        osc_rise    = osc_s2_r & ~osc_d_r;
  wire        ext_rise    = ext_s2_r & ~ext_d_r;
  wire        pin_rise    = osc_en ? osc_rise : ext_rise;
  wire        instr_tick  = instr_div_r == `SBTC_INSTR_DIV;

  // timer source stops with the core clock in sleep; pin source keeps running
  wire        src_event   = run && (src_ext ? pin_rise : (instr_tick && !SLEEP));
  wire        presc_out   = src_event && ps_hit(presc_r, ps_sel);

  // sync stage sits behind the prescaler and is off in sleep
  wire        tgl_edge    = tgl_s2_r ^ tgl_d_r;
  wire        inc_sync    = tgl_edge && !SLEEP;

  logic inc;
  always_comb begin
    inc = 1'b0;
    case (mode)
      sbtc_pkg::SBTC_MODE_TIMER: inc = presc_out;
      sbtc_pkg::SBTC_MODE_SYNC:  inc = inc_sync && run;
      sbtc_pkg::SBTC_MODE_ASYNC: inc = presc_out;
      default:                   inc = 1'b0;
    endcase
  end

  wire trig_raw = (CMP1_MODE_SELECT == `SBTC_CMP_SPECIAL && CMP1_MATCH) ||
                  (CMP2_MODE_SELECT == `SBTC_CMP_SPECIAL && CMP2_MATCH);
  // clearing in bypass mode would race the free-running count, so it is refused
  wire trig     = trig_raw && mode != sbtc_pkg::SBTC_MODE_ASYNC;
  wire wrap     = inc && count_r == 16'hFFFF && !trig && !wr_count;

  always_comb begin
    count_nxt = count_r;
    if (wr_low) begin
      count_nxt = {count_r[15:8], AVS_WRITEDATA[7:0]};
    end else if (wr_high) begin
      count_nxt = {AVS_WRITEDATA[7:0], count_r[7:0]};
    end else if (trig) begin
      count_nxt = 16'h0000;
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count holding register: deliberately outside the reset

  always_ff @(posedge CORE_CLK) begin
    count_r <= count_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and prescaler

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_d_r  <= 1'b0;
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r  <= 1'b0;
    end else begin
      osc_s1_r <= OSC_INPUT_PIN;
      osc_s2_r <= osc_s1_r;
      osc_d_r  <= osc_s2_r;
      ext_s1_r <= EXT_COUNT_CLOCK_PIN;
      ext_s2_r <= ext_s1_r;
      ext_d_r  <= ext_s2_r;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      presc_r     <= 3'h0;
      instr_div_r <= 2'h0;
      presc_tgl_r <= 1'b0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
      if (wr_count) begin
        presc_r <= 3'h0;
      end else if (src_event) begin
        presc_r <= presc_r + 3'h1;
      end
      if (presc_out) begin
        presc_tgl_r <= ~presc_tgl_r;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_d_r  <= 1'b0;
    end else begin
      tgl_s1_r <= presc_tgl_r;
      tgl_s2_r <= tgl_s1_r;
      tgl_d_r  <= tgl_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r    <= `SBTC_CTRL_RESET;
      flags_r   <= `SBTC_FLAGS_RESET;
      enables_r <= `SBTC_ENABLES_RESET;
      intctrl_r <= `SBTC_INTCTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= AVS_WRITEDATA[7:0] & `SBTC_CTRL_MASK;
      end
      if (wr_enables) begin
        enables_r <= AVS_WRITEDATA[7:0];
      end
      if (wr_intctrl) begin
        intctrl_r <= AVS_WRITEDATA[7:0];
      end
      // overflow set wins over a software clear in the same cycle
      flags_r <= (wr_flags ? AVS_WRITEDATA[7:0] : flags_r) |
                 {7'h00, wrap};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait state, then the answer

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `SBTC_IDX_CORE_INT_CTRL:  rd_byte = intctrl_r;
      `SBTC_IDX_PERIPH_FLAGS:   rd_byte = flags_r;
      `SBTC_IDX_COUNT_LOW:      rd_byte = count_r[7:0];
      `SBTC_IDX_COUNT_HIGH:     rd_byte = count_r[15:8];
      `SBTC_IDX_COUNTER_CTRL:   rd_byte = ctrl_r;
      `SBTC_IDX_PERIPH_ENABLES: rd_byte = enables_r;
      default:                  rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_state_r <= sbtc_pkg::SBTC_BUS_IDLE;
      rdata_r     <= 32'h0000_0000;
    end else begin
      case (bus_state_r)
        sbtc_pkg::SBTC_BUS_IDLE: begin
          if (req) begin
            bus_state_r <= sbtc_pkg::SBTC_BUS_ANSWER;
            rdata_r     <= {24'h000000, aligned ? rd_byte : 8'h00};
          end
        end
        sbtc_pkg::SBTC_BUS_ANSWER: begin
          bus_state_r <= sbtc_pkg::SBTC_BUS_IDLE;
        end
        default: begin
          bus_state_r <= sbtc_pkg::SBTC_BUS_IDLE;
        end
      endcase
    end
  end

  assign AVS_WAITREQUEST = req && bus_state_r != sbtc_pkg::SBTC_BUS_ANSWER;
  assign AVS_READDATA    = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign OSC_AMP_ENABLE = osc_en;
  assign TIMEBASE_VALID = mode != sbtc_pkg::SBTC_MODE_ASYNC;
  assign TIMEBASE_COUNT = count_r;
  assign OVERFLOW_IRQ   = flags_r[`SBTC_OVF_BIT] & enables_r[`SBTC_OVF_BIT];
  // only the free-running mode can still count, and so wake, while asleep
  assign WAKE_REQUEST   = OVERFLOW_IRQ && SLEEP && mode == sbtc_pkg::SBTC_MODE_ASYNC;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_count_write;
    wr_count;
  endsequence

  sequence s_prescaler_cleared;
    ##1 presc_r == 3'h0;
  endsequence

  property p_write_clears_presc;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      s_count_write |-> s_prescaler_cleared;
  endproperty
  a_write_clears_presc: assert property (p_write_clears_presc) else $error("prescaler not cleared");

  property p_trig_clears;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      trig && !wr_count |=> count_r == 16'h0000;
  endproperty
  a_trig_clears: assert property (p_trig_clears) else $error("trigger did not clear count");

  property p_trig_no_flag;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      trig && !flags_r[0] && !wr_flags |=> !flags_r[0];
  endproperty
  a_trig_no_flag: assert property (p_trig_no_flag) else $error("trigger set overflow flag");

  property p_write_wins;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      wr_low && trig_raw |=> count_r[7:0] == $past(AVS_WRITEDATA[7:0]);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("trigger beat write");

  property p_wrap_flag;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      inc && count_r == 16'hFFFF && !trig && !wr_count |=> count_r == 16'h0000 && flags_r[0];
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not flag");

  property p_stopped_holds;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      !run && !wr_count && !trig |=> $stable(count_r);
  endproperty
  a_stopped_holds: assert property (p_stopped_holds) else $error("stopped counter moved");

  property p_sync_sleep_frozen;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      SLEEP && mode == sbtc_pkg::SBTC_MODE_SYNC && !wr_count && !trig |=> $stable(count_r);
  endproperty
  a_sync_sleep_frozen: assert property (p_sync_sleep_frozen) else $error("sync count moved in sleep");

  property p_timer_rate;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      mode == sbtc_pkg::SBTC_MODE_TIMER && inc |=> !inc [*3];
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("timer faster than instruction rate");

  property p_sync_delay;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      presc_out && mode == sbtc_pkg::SBTC_MODE_SYNC && !SLEEP ##1 !SLEEP ##1 !SLEEP
        ##1 (run && mode == sbtc_pkg::SBTC_MODE_SYNC && !SLEEP) |-> inc;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("synchronised count late");

  property p_ctrl_reset;
    @(posedge CORE_CLK) $rose(RESET_N) |-> ctrl_r == `SBTC_CTRL_RESET;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not cleared by reset");

  property p_irq_gate;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      OVERFLOW_IRQ |-> enables_r[0] && flags_r[0];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_bus_answer;
    @(posedge CORE_CLK) disable iff (!RESET_N)
      req && bus_state_r == sbtc_pkg::SBTC_BUS_IDLE |-> AVS_WAITREQUEST ##1 (!req || !AVS_WAITREQUEST);
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not in one wait state");

endmodule // sbtc_timer

`default_nettype wire

// File: verification/sbtc_clock_source.sv
`timescale 1ns/1ps
`default_nettype none

module sbtc_clock_source (
  input  wire logic osc_amp_enable,
  output var logic  osc_pin,
  output var logic  ext_pin
);
  // both sources stand low between bursts; phase is unrelated to the core clock
  initial begin
    osc_pin = 1'b0;
    ext_pin = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // high and low each last several core clocks so the two-flop sampler sees them
  task automatic pulses(input int n, input bit use_osc);
    for (int i = 0; i < n; i++) begin
      #97;
      if (use_osc) begin
        // a crystal with its amplifier off does not swing
        if (osc_amp_enable === 1'b1) osc_pin = 1'b1;
      end else begin
        ext_pin = 1'b1;
      end
      #113;
      osc_pin = 1'b0;
      ext_pin = 1'b0;
    end
  endtask
endmodule // sbtc_clock_source

`default_nettype wire

// File: verification/sbtc_timer_bench.sv
`timescale 1ns/1ps
`include "sbtc_regs.svh"
`default_nettype none

module sbtc_timer_bench;
  localparam logic [9:0] A_INTC = {`SBTC_IDX_CORE_INT_CTRL, 2'b00};
  localparam logic [9:0] A_FLAG = {`SBTC_IDX_PERIPH_FLAGS, 2'b00};
  localparam logic [9:0] A_CNTL = {`SBTC_IDX_COUNT_LOW, 2'b00};
  localparam logic [9:0] A_CNTH = {`SBTC_IDX_COUNT_HIGH, 2'b00};
  localparam logic [9:0] A_CTRL = {`SBTC_IDX_COUNTER_CTRL, 2'b00};
  localparam logic [9:0] A_ENA  = {`SBTC_IDX_PERIPH_ENABLES, 2'b00};

  logic        clk, rst_n, rd, wr, sleep, m1, m2;
  logic [9:0]  address;
  logic [31:0] wdata, rdata;
  logic        waitreq, osc_pin, ext_pin, amp_en, tb_valid, irq, wake;
  logic [3:0]  mode1, mode2;
  logic [15:0] tb_count, c1, c2;
  logic [7:0]  b;
  int          fail_count, total_checks;

  sbtc_timer sbtc_timer_inst (.CORE_CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(address), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .OSC_INPUT_PIN(osc_pin), .EXT_COUNT_CLOCK_PIN(ext_pin), .SLEEP(sleep),
    .CMP1_MODE_SELECT(mode1), .CMP1_MATCH(m1), .CMP2_MODE_SELECT(mode2), .CMP2_MATCH(m2),
    .OSC_AMP_ENABLE(amp_en), .TIMEBASE_VALID(tb_valid), .TIMEBASE_COUNT(tb_count),
    .OVERFLOW_IRQ(irq), .WAKE_REQUEST(wake));

  sbtc_clock_source sbtc_clock_source_inst (.osc_amp_enable(amp_en), .osc_pin(osc_pin), .ext_pin(ext_pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one request held until waitrequest is sampled low
  task automatic bus(input logic is_wr, input logic [9:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    wdata <= {24'h000000, d};
    if (is_wr) wr <= 1'b1;
    else rd <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    if (n >= 50) check("bus answer", 16'h0000, 16'h0001);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic wrb(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d, b);
  endtask

  task automatic rdc(input logic [9:0] a, input logic [7:0] exp, input string what);
    bus(1'b0, a, 8'h00, b);
    check(what, {8'h00, exp}, {8'h00, b});
  endtask

  task automatic cnt(input logic [15:0] exp, input string what);
    rdc(A_CNTL, exp[7:0], what);
    rdc(A_CNTH, exp[15:8], what);
  endtask

  task automatic trig(input logic unit2, input logic [3:0] m);
    @(posedge clk);
    mode1 <= m;
    mode2 <= m;
    if (unit2) m2 <= 1'b1;
    else m1 <= 1'b1;
    @(posedge clk);
    m1 <= 1'b0;
    m2 <= 1'b0;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    $display("mismatch watchdog expected finish seen hang");
    close_out();
  end

  initial begin
    {rst_n, rd, wr, sleep, m2} = 5'h00;
    // count has no reset; a trigger held through reset gives it a known start
    m1 = 1'b1;
    address = 10'h000;
    wdata = 32'h00000000;
    mode1 = `SBTC_CMP_SPECIAL;
    mode2 = 4'h0;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    m1 <= 1'b0;
    rdc(A_CTRL, 8'h00, "ctrl reset");
    rdc(A_FLAG, 8'h00, "flags reset");
    rdc(A_ENA, 8'h00, "enables reset");
    rdc(A_INTC, 8'h00, "intctrl reset");
    rdc(10'h3FC, 8'h00, "unmapped");
    wrb(A_CNTL, 8'h34);
    wrb(A_CNTH, 8'h12);
    trig(1'b0, 4'hA);
    cnt(16'h1234, "other mode no clear");
    trig(1'b0, `SBTC_CMP_SPECIAL);
    cnt(16'h0000, "unit one clear");
    rdc(A_FLAG, 8'h00, "clear sets no flag");
    wrb(A_CNTL, 8'h34);
    trig(1'b1, `SBTC_CMP_SPECIAL);
    cnt(16'h0000, "unit two clear");
    // timer mode; bypass bit set but must be ignored
    wrb(A_CTRL, 8'h05);
    check("timebase valid", 16'h0001, {15'h0000, tb_valid});
    repeat (40) @(posedge clk);
    wrb(A_CTRL, 8'h00);
    bus(1'b0, A_CNTL, 8'h00, c1[7:0]);
    bus(1'b0, A_CNTH, 8'h00, c1[15:8]);
    check("timer rate", 16'h0001, {15'h0000, (c1 >= 16'h0009 && c1 <= 16'h000C)});
    repeat (20) @(posedge clk);
    check("count held", c1, tb_count);
    // write lands at the same edge as a trigger
    fork
      wrb(A_CNTL, 8'h55);
      begin
        @(posedge clk iff (wr === 1'b1 && waitreq === 1'b1));
        m1 <= 1'b1;
        @(posedge clk);
        m1 <= 1'b0;
      end
    join
    cnt({c1[15:8], 8'h55}, "write beats trigger");
    for (int k = 0; k < 4; k++) begin
      wrb(A_CNTL, 8'h00);
      wrb(A_CNTH, 8'h00);
      wrb(A_CTRL, 8'(k * 16 + 7));
      sbtc_clock_source_inst.pulses(16, 1'b0);
      repeat (5) @(posedge clk);
      check("async not timebase", 16'h0000, {15'h0000, tb_valid});
      cnt(16'(16 >> k), "prescale");
    end
    trig(1'b0, `SBTC_CMP_SPECIAL);
    cnt(16'h0002, "async ignores trigger");
    wrb(A_CTRL, 8'h37);
    sbtc_clock_source_inst.pulses(6, 1'b0);
    wrb(A_CNTL, 8'h00);
    sbtc_clock_source_inst.pulses(4, 1'b0);
    cnt(16'h0000, "prescaler cleared");
    sbtc_clock_source_inst.pulses(4, 1'b0);
    cnt(16'h0001, "prescaler after clear");
    // synchronised counting freezes in sleep
    wrb(A_CTRL, 8'h00);
    wrb(A_CNTL, 8'h00);
    wrb(A_CTRL, 8'h03);
    sleep <= 1'b1;
    sbtc_clock_source_inst.pulses(8, 1'b0);
    repeat (5) @(posedge clk);
    sleep <= 1'b0;
    cnt(16'h0000, "sync sleep frozen");
    sbtc_clock_source_inst.pulses(5, 1'b0);
    repeat (10) @(posedge clk);
    cnt(16'h0005, "sync count");
    // crystal in sleep, asynchronous overflow wakes the core
    wrb(A_CTRL, 8'h00);
    wrb(A_CNTL, 8'hFE);
    wrb(A_CNTH, 8'hFF);
    wrb(A_ENA, 8'h01);
    wrb(A_CTRL, 8'h0F);
    repeat (50) @(posedge clk);
    sleep <= 1'b1;
    sbtc_clock_source_inst.pulses(3, 1'b0);
    repeat (5) @(posedge clk);
    check("ext pin unused", 16'hFFFE, tb_count);
    check("osc runs in sleep", 16'h0001, {15'h0000, amp_en});
    sbtc_clock_source_inst.pulses(2, 1'b1);
    repeat (5) @(posedge clk);
    check("wrap to zero", 16'h0000, tb_count);
    check("irq", 16'h0001, {15'h0000, irq});
    check("wake", 16'h0001, {15'h0000, wake});
    rdc(A_FLAG, 8'h01, "overflow flag");
    sleep <= 1'b0;
    wrb(A_ENA, 8'h00);
    // the enable write lands at the edge the task returns on
    @(posedge clk);
    check("irq masked", 16'h0000, {15'h0000, irq});
    rdc(A_FLAG, 8'h01, "flag sticky");
    wrb(A_FLAG, 8'h00);
    rdc(A_FLAG, 8'h00, "flag cleared");
    close_out();
  end
endmodule // sbtc_timer_bench

`default_nettype wire
